// File: logic/ars_config_regs.sv
/*
  configuration register bank of a three-axis angular-rate sensor:
  range, filter and rate, power state, keyed soft reset, new-sample irq.
  assumes the serial host port delivers single-cycle register reads and
  writes on the core clock, and the sensor core pulses new_sample_i.
*/
// Overview of operation
// - range codes 0x00..0x04 give 2000,1000,500,250,125 dps; reset 0x00.
// - filter codes 0x00..0x07 give fixed pairs of output rate and bandwidth.
// - filter register bit 7 ignores writes, reads one, resets to 0x80.
// - power register 0x00 is normal, 0x80 suspend; resets to normal.
// - only writing 0xb6 to the reset command starts a soft reset.
// - thirty milliseconds after the command all configuration returns to reset.
// - soft reset command is accepted in every power state.
// - irq control resets disabled; 0x80 raises irq on each new sample.
// - new-sample flag clears itself 280 to 400 microseconds after setting.
// - route 0x00 none, 0x01 first pin, 0x80 second, 0x81 both.
`timescale 1ns/100ps
module ars_config_regs
  import ars_pkg::*;
#(
  parameter int unsigned SRST_CYC = SRST_DELAY_CYC,
  parameter int unsigned CLEAR_CYC = FLAG_CLEAR_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic new_sample_i,
  output logic [11:0] full_scale_dps_o,
  output logic [11:0] odr_hz_o,
  output logic [9:0] filter_bw_hz_o,
  output logic pwr_suspend_o,
  output logic pwr_deep_suspend_o,
  output logic soft_reset_busy_o,
  output logic new_sample_flag_o,
  output logic irq_out_a_o,
  output logic irq_out_b_o
);

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [11:0] range_dps(input logic [7:0] code);
    logic [11:0] dps;
    dps = 12'h000;
    case (code)
      8'h00: dps = 12'd2000;
      8'h01: dps = 12'd1000;
      8'h02: dps = 12'd500;
      8'h03: dps = 12'd250;
      8'h04: dps = 12'd125;
      default: dps = 12'h000;
    endcase
    return dps;
  endfunction

  function automatic logic [21:0] filter_pair(input logic [6:0] code);
    logic [21:0] pair;
    pair = 22'h000000;
    case (code)
      7'h00: pair = {12'd2000, 10'd532};
      7'h01: pair = {12'd2000, 10'd230};
      7'h02: pair = {12'd1000, 10'd116};
      7'h03: pair = {12'd400, 10'd47};
      7'h04: pair = {12'd200, 10'd23};
      7'h05: pair = {12'd100, 10'd12};
      7'h06: pair = {12'd200, 10'd64};
      7'h07: pair = {12'd100, 10'd32};
      default: pair = 22'h000000;
    endcase
    return pair;
  endfunction

  function automatic logic is_wr(input logic wr, input logic [7:0] addr,
                                 input logic [7:0] ofs);
    return wr && (addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] full_scale;
    logic [6:0] filter_odr;
    logic [7:0] power_state;
    logic [7:0] irq_control;
    logic [7:0] irq_route;
    ars_srst_e srst;
    logic [CNT_W-1:0] srst_cnt;
    logic [7:0] rdata;
  } ars_regs_s;

  ars_regs_s st;
  ars_regs_s next_st;
  logic [21:0] pair;

  ars_flag_if fl ();
  logic key_hit;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign key_hit = is_wr(reg_wr_i, reg_addr_i, OFS_RESET_CMD) &&
                   (reg_wdata_i == SOFT_RESET_KEY);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (is_wr(reg_wr_i, reg_addr_i, OFS_FULL_SCALE)) begin
      next_st.full_scale = reg_wdata_i;
    end
    if (is_wr(reg_wr_i, reg_addr_i, OFS_FILTER_ODR)) begin
      next_st.filter_odr = reg_wdata_i[6:0] & FILTER_ODR_WMASK[6:0];
    end
    if (is_wr(reg_wr_i, reg_addr_i, OFS_POWER_STATE)) begin
      next_st.power_state = reg_wdata_i;
    end
    if (is_wr(reg_wr_i, reg_addr_i, OFS_IRQ_CONTROL)) begin
      next_st.irq_control = reg_wdata_i;
    end
    if (is_wr(reg_wr_i, reg_addr_i, OFS_IRQ_ROUTE)) begin
      next_st.irq_route = reg_wdata_i;
    end
    // soft reset sequencer
    case (st.srst)
      SR_IDLE: begin
        next_st.srst_cnt = '0;
      end
      SR_WAIT: begin
        if (st.srst_cnt == CNT_W'(SRST_CYC - 1)) begin
          next_st.full_scale = RST_FULL_SCALE;
          next_st.filter_odr = RST_FILTER_ODR[6:0];
          next_st.power_state = RST_POWER_STATE;
          next_st.irq_control = RST_IRQ_CONTROL;
          next_st.irq_route = RST_IRQ_ROUTE;
          next_st.srst = SR_IDLE;
          next_st.srst_cnt = '0;
        end else begin
          next_st.srst_cnt = st.srst_cnt + CNT_W'(1);
        end
      end
      default: begin
        next_st.srst = SR_IDLE;
        next_st.srst_cnt = '0;
      end
    endcase
    // key accepted regardless of power state; a repeat restarts the wait
    if (key_hit) begin
      next_st.srst = SR_WAIT;
      next_st.srst_cnt = '0;
    end
    // read port
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_FULL_SCALE: next_st.rdata = st.full_scale;
        OFS_FILTER_ODR: next_st.rdata = FILTER_ODR_FIXED | {1'b0, st.filter_odr};
        OFS_POWER_STATE: next_st.rdata = st.power_state;
        OFS_IRQ_CONTROL: next_st.rdata = st.irq_control;
        OFS_IRQ_ROUTE: next_st.rdata = st.irq_route;
        OFS_RESET_CMD: next_st.rdata = 8'h00;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st.full_scale <= RST_FULL_SCALE;
      st.filter_odr <= RST_FILTER_ODR[6:0];
      st.power_state <= RST_POWER_STATE;
      st.irq_control <= RST_IRQ_CONTROL;
      st.irq_route <= RST_IRQ_ROUTE;
      st.srst <= SR_IDLE;
      st.srst_cnt <= '0;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // flag timer
  // ----------------------------------------------------------------
  assign fl.sample_evt = new_sample_i;
  assign fl.irq_enable = (st.irq_control == IRQ_CTRL_ENABLE);
  assign fl.route = st.irq_route;

  ars_sample_flag #(
    .CLEAR_CYC(CLEAR_CYC)
  ) u_flag (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .fl(fl)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pair = filter_pair(st.filter_odr);
  assign reg_rdata_o = st.rdata;
  assign full_scale_dps_o = range_dps(st.full_scale);
  assign odr_hz_o = pair[21:10];
  assign filter_bw_hz_o = pair[9:0];
  assign pwr_suspend_o = (st.power_state == PWR_SUSPEND);
  assign pwr_deep_suspend_o = (st.power_state == PWR_DEEP_SUSPEND);
  assign soft_reset_busy_o = (st.srst == SR_WAIT);
  assign new_sample_flag_o = fl.flag;
  assign irq_out_a_o = fl.irq_a;
  assign irq_out_b_o = fl.irq_b;

endmodule

// File: logic/ars_pkg.sv
/*
  constants, encodings and timing counts of the angular-rate sensor
  configuration registers.
  assumes a 40 mhz core clock shared by every module that imports it.
*/
package ars_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FULL_SCALE = 8'h0f;
  localparam logic [7:0] OFS_FILTER_ODR = 8'h10;
  localparam logic [7:0] OFS_POWER_STATE = 8'h11;
  localparam logic [7:0] OFS_RESET_CMD = 8'h14;
  localparam logic [7:0] OFS_IRQ_CONTROL = 8'h15;
  localparam logic [7:0] OFS_IRQ_ROUTE = 8'h18;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FULL_SCALE = 8'h00;
  localparam logic [7:0] RST_FILTER_ODR = 8'h80;
  localparam logic [7:0] RST_POWER_STATE = 8'h00;
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_ROUTE = 8'h00;
  localparam logic [7:0] FILTER_ODR_FIXED = 8'h80;
  localparam logic [7:0] FILTER_ODR_WMASK = 8'h7f;

  // ----------------------------------------------------------------
  // command and mode codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SOFT_RESET_KEY = 8'hb6;
  localparam logic [7:0] PWR_NORMAL = 8'h00;
  localparam logic [7:0] PWR_SUSPEND = 8'h80;
  localparam logic [7:0] PWR_DEEP_SUSPEND = 8'h20;
  localparam logic [7:0] IRQ_CTRL_ENABLE = 8'h80;
  localparam logic [7:0] ROUTE_PIN_A = 8'h01;
  localparam logic [7:0] ROUTE_PIN_B = 8'h80;
  localparam logic [7:0] ROUTE_PIN_AB = 8'h81;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SRST_DELAY_MS = 30;
  localparam int unsigned SRST_DELAY_CYC = SRST_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned FLAG_CLEAR_US = 280;
  localparam int unsigned FLAG_CLEAR_CYC =
    (FLAG_CLEAR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;

  typedef enum logic [0:0] {SR_IDLE, SR_WAIT} ars_srst_e;

endpackage

// File: logic/ars_flag_if.sv
/*
  carrier between the register bank and the new-sample flag timer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface ars_flag_if;
  logic sample_evt;
  logic irq_enable;
  logic [7:0] route;
  logic flag;
  logic irq_a;
  logic irq_b;
  modport ctrl (output sample_evt, output irq_enable, output route,
                input flag, input irq_a, input irq_b);
  modport timer (input sample_evt, input irq_enable, input route,
                 output flag, output irq_a, output irq_b);
endinterface

// File: logic/ars_sample_flag.sv
/*
  new-sample status flag with self clearing, and its routing to the two
  interrupt outputs.
  assumes sample_evt is a one-cycle pulse on the same clock.
*/
`timescale 1ns/100ps
module ars_sample_flag
  import ars_pkg::*;
#(
  parameter int unsigned CLEAR_CYC = FLAG_CLEAR_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  ars_flag_if.timer fl
);

  typedef struct packed {
    logic flag;
    logic [CNT_W-1:0] cnt;
    logic irq_a;
    logic irq_b;
  } ars_flag_s;

  ars_flag_s st;
  ars_flag_s next_st;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (fl.sample_evt) begin
      next_st.flag = 1'b1;
      next_st.cnt = '0;
    end else if (st.flag) begin
      if (st.cnt == CNT_W'(CLEAR_CYC - 1)) begin
        next_st.flag = 1'b0;
      end else begin
        next_st.cnt = st.cnt + CNT_W'(1);
      end
    end
    next_st.irq_a = next_st.flag && fl.irq_enable &&
                    (fl.route == ROUTE_PIN_A || fl.route == ROUTE_PIN_AB);
    next_st.irq_b = next_st.flag && fl.irq_enable &&
                    (fl.route == ROUTE_PIN_B || fl.route == ROUTE_PIN_AB);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fl.flag = st.flag;
  assign fl.irq_a = st.irq_a;
  assign fl.irq_b = st.irq_b;

endmodule

// File: tb/ars_cfg_properties.sv
/*
  port checker of the configuration register bank.
  assumes bind to ars_config_regs with the same counts.
*/
`timescale 1ns/100ps
module ars_cfg_properties #(
  parameter int unsigned SRST_CYC = 20,
  parameter int unsigned CLEAR_CYC = 8
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic new_sample_i,
  input wire logic [11:0] full_scale_dps_o,
  input wire logic [11:0] odr_hz_o,
  input wire logic [9:0] filter_bw_hz_o,
  input wire logic pwr_suspend_o,
  input wire logic pwr_deep_suspend_o,
  input wire logic soft_reset_busy_o,
  input wire logic new_sample_flag_o,
  input wire logic irq_out_a_o,
  input wire logic irq_out_b_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ----
  // write and sample sequences
  // ----
  sequence wr_s(a, d);
    reg_wr_i && reg_addr_i == a && reg_wdata_i == d && !soft_reset_busy_o;
  endsequence
  sequence quiet_s;
    new_sample_i ##1 !new_sample_i [*7];
  endsequence
  chk_range_min: assert property (wr_s(8'h0f, 8'h04) |=> full_scale_dps_o == 12'd125)
    else $error("range code 4 wrong");
  chk_filter_fixed: assert property (reg_rd_i && reg_addr_i == 8'h10 |=> reg_rdata_o[7])
    else $error("filter bit 7 not one");
  chk_pwr_suspend: assert property (wr_s(8'h11, 8'h80) |=>
    pwr_suspend_o && !pwr_deep_suspend_o)
    else $error("suspend decode wrong");
  chk_pwr_deep: assert property (wr_s(8'h11, 8'h20) |=>
    pwr_deep_suspend_o && !pwr_suspend_o)
    else $error("deep suspend decode wrong");
  chk_reset_start: assert property (wr_s(8'h14, 8'hb6) |=> soft_reset_busy_o)
    else $error("reset key not taken");
  chk_reset_key: assert property (reg_wr_i && reg_addr_i == 8'h14 && reg_wdata_i != 8'hb6
    && !soft_reset_busy_o |=> !soft_reset_busy_o)
    else $error("wrong key started reset");
  chk_restore_time: assert property (wr_s(8'h14, 8'hb6) |-> ##SRST_CYC soft_reset_busy_o ##1
    (!soft_reset_busy_o && full_scale_dps_o == 12'd2000 && odr_hz_o == 12'd2000
    && filter_bw_hz_o == 10'd532 && !pwr_suspend_o && !pwr_deep_suspend_o))
    else $error("restore late or incomplete");
  chk_flag_set: assert property (new_sample_i |=> new_sample_flag_o)
    else $error("flag not set");
  chk_flag_clear: assert property (quiet_s |=>
    new_sample_flag_o ##[1:4] !new_sample_flag_o)
    else $error("flag clear timing wrong");
  chk_irq_gated: assert property (irq_out_a_o || irq_out_b_o |-> new_sample_flag_o)
    else $error("irq without flag");
endmodule

// File: tb/ars_host_model.sv
/*
  host processor model on the register strobe port.
  assumes the bench calls one task at a time.
*/
`timescale 1ns/100ps
module ars_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] reg_rdata_o,
  output logic reg_wr_i = 1'b0,
  output logic reg_rd_i = 1'b0,
  output logic [7:0] reg_addr_i = 8'h00,
  output logic [7:0] reg_wdata_i = 8'h00
);
  logic [7:0] pwr_now = 8'h00;
  // ----
  // strobe port cycles
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i <= 1'b0;
    reg_addr_i <= ~a;
    reg_wdata_i <= ~d;
    if (a == 8'h14 && d == 8'hb6) begin
      pwr_now = 8'h00;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i <= 1'b0;
    reg_addr_i <= ~a;
    d = reg_rdata_o;
  endtask
  // passes through normal between suspend states, listed codes only
  task automatic pwr(input logic [7:0] code);
    if (pwr_now != 8'h00 && code != 8'h00 && code != pwr_now) begin
      wr(8'h11, 8'h00);
    end
    wr(8'h11, code);
    pwr_now = code;
  endtask
endmodule

// File: tb/test_angular_rate_sensor_config_regs.sv
/*
  self-checking bench of the configuration register bank.
  assumes shortened restore and flag counts.
*/
`timescale 1ns/100ps
module test_angular_rate_sensor_config_regs;
  localparam int unsigned SRST_CYC = 20;
  localparam int unsigned CLEAR_CYC = 8;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic new_sample_i = 1'b0;
  logic reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
  logic [11:0] full_scale_dps_o, odr_hz_o;
  logic [9:0] filter_bw_hz_o;
  logic pwr_suspend_o, pwr_deep_suspend_o, soft_reset_busy_o;
  logic new_sample_flag_o, irq_out_a_o, irq_out_b_o;
  int fails = 0;
  int checks = 0;
  logic [7:0] ofs_tab [7] = '{8'h0f, 8'h10, 8'h11, 8'h14, 8'h15, 8'h18, 8'h30};
  logic [7:0] rst_tab [7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [11:0] dps_tab [5] = '{12'd2000, 12'd1000, 12'd500, 12'd250, 12'd125};
  logic [11:0] odr_tab [8] = '{12'd2000, 12'd2000, 12'd1000, 12'd400, 12'd200, 12'd100,
    12'd200, 12'd100};
  logic [11:0] bw_tab [8] = '{12'd532, 12'd230, 12'd116, 12'd47, 12'd23, 12'd12, 12'd64, 12'd32};
  logic [7:0] route_tab [4] = '{8'h00, 8'h01, 8'h80, 8'h81};
  ars_config_regs #(.SRST_CYC(SRST_CYC), .CLEAR_CYC(CLEAR_CYC)) dut_u (.*);
  ars_host_model host_u (.*);
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // ----
  // compare, pulse and closing
  // ----
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse;
    @(negedge ref_clk_i);
    new_sample_i = 1'b1;
    @(negedge ref_clk_i);
    new_sample_i = 1'b0;
  endtask
  task automatic stop_test;
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    fails++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    for (int i = 0; i < 7; i++) begin
      host_u.rd(ofs_tab[i], rv);
      chk("reset read", {4'h0, rst_tab[i]}, {4'h0, rv});
    end
    for (int i = 0; i < 5; i++) begin
      host_u.wr(8'h0f, 8'(i));
      chk("full scale", dps_tab[i], full_scale_dps_o);
    end
    for (int i = 0; i < 8; i++) begin
      host_u.wr(8'h10, 8'(i));
      chk("odr", odr_tab[i], odr_hz_o);
      chk("bandwidth", bw_tab[i], {2'b00, filter_bw_hz_o});
      host_u.rd(8'h10, rv);
      chk("filter read", {4'h0, 8'h80 | 8'(i)}, {4'h0, rv});
    end
    host_u.pwr(8'h80);
    chk("suspend", 12'h1, {11'h0, pwr_suspend_o});
    host_u.rd(8'h11, rv);
    chk("power read", 12'h080, {4'h0, rv});
    host_u.pwr(8'h20);
    chk("deep suspend", 12'h1, {11'h0, pwr_deep_suspend_o});
    chk("not suspend", 12'h0, {11'h0, pwr_suspend_o});
    host_u.wr(8'h14, 8'h55);
    chk("busy", 12'h0, {11'h0, soft_reset_busy_o});
    host_u.wr(8'h14, 8'hb6);
    chk("busy", 12'h1, {11'h0, soft_reset_busy_o});
    repeat (SRST_CYC - 1) @(negedge ref_clk_i);
    chk("before restore", 12'd125, full_scale_dps_o);
    chk("busy wait", 12'h1, {11'h0, soft_reset_busy_o});
    @(negedge ref_clk_i);
    chk("restored", 12'd2000, full_scale_dps_o);
    chk("restored deep", 12'h0, {11'h0, pwr_deep_suspend_o});
    chk("busy done", 12'h0, {11'h0, soft_reset_busy_o});
    host_u.rd(8'h10, rv);
    chk("restored filter", 12'h080, {4'h0, rv});
    host_u.wr(8'h15, 8'h80);
    host_u.rd(8'h15, rv);
    chk("irq control read", 12'h080, {4'h0, rv});
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'h18, route_tab[i]);
      pulse();
      chk("flag", 12'h1, {11'h0, new_sample_flag_o});
      chk("irq a", {11'h0, route_tab[i][0]}, {11'h0, irq_out_a_o});
      chk("irq b", {11'h0, route_tab[i][7]}, {11'h0, irq_out_b_o});
      repeat (CLEAR_CYC + 2) @(negedge ref_clk_i);
      chk("flag", 12'h0, {11'h0, new_sample_flag_o});
      chk("irq clear", 12'h0, {10'h0, irq_out_a_o, irq_out_b_o});
    end
    host_u.wr(8'h15, 8'h00);
    pulse();
    chk("irq off", 12'h0, {10'h0, irq_out_a_o, irq_out_b_o});
    chk("flag unmasked", 12'h1, {11'h0, new_sample_flag_o});
    stop_test();
  end
endmodule
bind ars_config_regs ars_cfg_properties #(.SRST_CYC(SRST_CYC), .CLEAR_CYC(CLEAR_CYC)) chk_u (.*);
